// ===== src/seec_defines.vh
/*
  constants of the ecc sram wrapper: storage size, register offsets,
  field positions, reset values and access size codes.
  assumes inclusion by bare name from the design files of this block.
*/
`ifndef SEEC_DEFINES_VH
`define SEEC_DEFINES_VH

// storage shape
`define SEEC_DATA_W 32
`define SEEC_CHECK_W 7
`define SEEC_WORD_W 39
`define SEEC_ADDR_W 8
`define SEEC_IDX_W 6
`define SEEC_DEPTH 64

// access size codes on mem_size
`define SEEC_SIZE_BYTE 2'h0
`define SEEC_SIZE_HALF 2'h1
`define SEEC_SIZE_WORD 2'h2

// register byte offsets
`define SEEC_REG_STATUS 8'h00
`define SEEC_REG_CLEAR 8'h04
`define SEEC_REG_ENABLE 8'h08
`define SEEC_REG_ERR_ADDR 8'h0c
`define SEEC_REG_ERR_POS 8'h10
`define SEEC_REG_INJECT 8'h14

// field positions in status, clear and enable
`define SEEC_BIT_SINGLE 0
`define SEEC_BIT_MULTI 1
// data-bit-hit marker in the error position register
`define SEEC_BIT_POS_HIT 8

// reset values
`define SEEC_RST_FLAGS 2'h0
`define SEEC_RST_ENABLE 2'h0
`define SEEC_RST_ADDR 8'h00
`define SEEC_RST_POS 6'h00
`define SEEC_RST_INJECT 32'h00000000

`endif

// ===== src/seec_encoder.v
/*
  check-code encoder: six hamming bits plus one overall parity bit over
  a 32-bit data word. purely combinational.
  assumes the caller stores the code beside the data in the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "seec_defines.vh"

module seec_encoder (
  // data in
  input wire [`SEEC_DATA_W-1:0] enc_data,
  // check code out, overall parity on top
  output wire [`SEEC_CHECK_W-1:0] enc_check
);

  reg [5:0] ham;
  integer i;
  integer k;
  integer p;
  integer n;

  // data bit i sits at the i-th codeword position that is no power of two
  always @* begin
    ham = 6'h00;
    n = 0;
    i = 0;
    for (p = 1; p < `SEEC_WORD_W; p = p + 1) begin
      if ((p & (p - 1)) != 0) begin
        i = n;
        for (k = 0; k < 6; k = k + 1) begin
          if (p[k]) begin
            ham[k] = ham[k] ^ enc_data[i];
          end
        end
        n = n + 1;
      end
    end
  end

  // overall parity makes the whole 39-bit word even
  assign enc_check = {^{enc_data, ham}, ham};

endmodule // seec_encoder
`default_nettype wire

// ===== src/seec_decoder.v
/*
  check-code decoder: recomputes the code with the encoder, corrects one
  flipped bit and flags two flipped bits. purely combinational.
  assumes the stored word holds data in bits 31:0 and the code above it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "seec_defines.vh"

module seec_decoder (
  // stored word in
  input wire [`SEEC_WORD_W-1:0] dec_word,
  // corrected data and status out
  output wire [`SEEC_DATA_W-1:0] dec_data,
  output wire dec_single,
  output wire dec_double,
  output reg [5:0] dec_pos,
  output wire dec_pos_hit
);

  wire [`SEEC_CHECK_W-1:0] re_check;
  wire [5:0] syn;
  wire par_bad;
  wire [`SEEC_DATA_W-1:0] hit;
  integer j;

  // recompute with the very same encoder
  seec_encoder u_recode (
    .enc_data(dec_word[`SEEC_DATA_W-1:0]),
    .enc_check(re_check)
  );

  assign syn = re_check[5:0] ^ dec_word[37:32];
  assign par_bad = ^dec_word;

  // one-hot encodes give each data bit's syndrome column
  genvar g;
  generate
    for (g = 0; g < `SEEC_DATA_W; g = g + 1) begin : g_col
      wire [`SEEC_CHECK_W-1:0] col;
      seec_encoder u_col (
        .enc_data(32'h00000001 << g),
        .enc_check(col)
      );
      assign hit[g] = (col[5:0] == syn) && (syn != 6'h00);
    end
  endgenerate

  // odd parity: one flip; even parity with syndrome: two flips
  assign dec_single = par_bad;
  assign dec_double = !par_bad && (syn != 6'h00);
  assign dec_data = dec_word[`SEEC_DATA_W-1:0] ^ (par_bad ? hit : 32'h00000000);
  assign dec_pos_hit = par_bad && (|hit);

  // index of the flipped data bit
  always @* begin
    dec_pos = 6'h00;
    for (j = 0; j < `SEEC_DATA_W; j = j + 1) begin
      if (hit[j]) begin
        dec_pos = j[5:0];
      end
    end
  end

endmodule // seec_decoder
`default_nettype wire

// ===== src/seec_top.v
/*
  ecc-protected sram with error status and interrupt control: a word
  store of flip-flops with a 7-bit check code per word, read-modify-write
  for narrow writes, sticky error flags, error address capture, a normal
  and a non-maskable interrupt.
  assumes one clock, memory masters that honour mem_ready, and software
  that fills the store with full word writes before reading it.

*/
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "seec_defines.vh"

module seec_top (
  // clock and reset
  input wire core_clk,
  input wire rst_b,

  // memory access port
  input wire mem_req,
  input wire mem_we,
  input wire [1:0] mem_size,
  input wire [`SEEC_ADDR_W-1:0] mem_addr,
  input wire [`SEEC_DATA_W-1:0] mem_wdata,
  output wire mem_ready,
  output reg mem_rvalid,
  output reg [`SEEC_DATA_W-1:0] mem_rdata,
  output reg mem_rerr,

  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,

  // interrupts
  output wire ecc_irq,
  output wire ecc_nmi
);

  // sequencer states
  localparam ST_IDLE = 1'b0;
  localparam ST_MERGE = 1'b1;

  // reset state of the two enables, in register layout
  localparam [1:0] RST_EN = `SEEC_RST_ENABLE;

  // lane mask of an access: one bit per byte written
  function [3:0] lane_mask;
    input [1:0] size;
    input [1:0] low;
    begin
      case (size)
        `SEEC_SIZE_BYTE: begin
          lane_mask = 4'h1 << low;
        end
        `SEEC_SIZE_HALF: begin
          lane_mask = low[1] ? 4'hc : 4'h3;
        end
        default: begin
          lane_mask = 4'hf;
        end
      endcase
    end
  endfunction

  // register port decode, shared by the write strobes
  function reg_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // storage, data in 31:0 and code in 38:32
  reg [`SEEC_WORD_W-1:0] store [0:`SEEC_DEPTH-1];

  // sequencer and held write
  reg state;
  reg next_state;
  reg [`SEEC_ADDR_W-1:0] hold_addr;
  reg [`SEEC_DATA_W-1:0] hold_data;
  reg [3:0] hold_mask;

  // control and status
  reg single_bit_err_flag;
  reg multi_bit_err_flag;
  reg single_bit_err_int_en;
  reg multi_bit_err_nmi_en;
  reg [`SEEC_ADDR_W-1:0] ecc_error_addr_reg;
  reg [5:0] err_pos;
  reg err_pos_hit;
  reg [`SEEC_DATA_W-1:0] inject_mask;
  reg next_single_flag;
  reg next_multi_flag;

  // datapath nets
  wire [`SEEC_IDX_W-1:0] rd_idx;
  wire [`SEEC_WORD_W-1:0] rd_word;
  wire [`SEEC_DATA_W-1:0] dec_data;
  wire dec_single;
  wire dec_double;
  wire [5:0] dec_pos;
  wire dec_pos_hit;
  wire [`SEEC_DATA_W-1:0] wr_data;
  wire [`SEEC_CHECK_W-1:0] wr_check;
  wire [3:0] req_mask;
  wire take_read;
  wire take_full_write;
  wire take_part_write;
  wire do_write;
  wire [`SEEC_IDX_W-1:0] wr_idx;
  wire ev_single;
  wire ev_double;
  wire clear_wr;
  wire enable_wr;
  wire inject_wr;
  wire [1:0] flags;
  wire [1:0] enables;
  reg [`SEEC_DATA_W-1:0] merged;
  integer b;

  // accepting side of the memory port
  assign mem_ready = (state == ST_IDLE);
  assign req_mask = lane_mask(mem_size, mem_addr[1:0]);
  assign take_read = mem_ready && mem_req && !mem_we;
  assign take_full_write = mem_ready && mem_req && mem_we && (req_mask == 4'hf);
  assign take_part_write = mem_ready && mem_req && mem_we && (req_mask != 4'hf);

  // whole containing word is always read, low address bits ignored
  assign rd_idx = (state == ST_MERGE) ? hold_addr[`SEEC_ADDR_W-1:2]
                                      : mem_addr[`SEEC_ADDR_W-1:2];
  assign rd_word = store[rd_idx];

  // decode of the stored word
  seec_decoder u_decoder (
    .dec_word(rd_word),
    .dec_data(dec_data),
    .dec_single(dec_single),
    .dec_double(dec_double),
    .dec_pos(dec_pos),
    .dec_pos_hit(dec_pos_hit)
  );

  // merge new bytes over the corrected old word
  always @* begin
    merged = dec_data;
    for (b = 0; b < 4; b = b + 1) begin
      if (hold_mask[b]) begin
        merged[b*8 +: 8] = hold_data[b*8 +: 8];
      end
    end
  end

  // write data with the test flip mask applied after encoding
  assign wr_data = (state == ST_MERGE) ? merged : mem_wdata;
  assign do_write = take_full_write || (state == ST_MERGE);
  assign wr_idx = (state == ST_MERGE) ? hold_addr[`SEEC_ADDR_W-1:2]
                                      : mem_addr[`SEEC_ADDR_W-1:2];

  seec_encoder u_encoder (
    .enc_data(wr_data),
    .enc_check(wr_check)
  );

  // storage write port, data and code in one edge
  always @(posedge core_clk) begin
    if (do_write) begin
      store[wr_idx] <= {wr_check, wr_data ^ inject_mask};
    end
  end

  // sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_part_write) begin
          next_state = ST_MERGE;
        end
      end
      ST_MERGE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer state and held narrow write
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      hold_addr <= `SEEC_RST_ADDR;
      hold_data <= 32'h00000000;
      hold_mask <= 4'h0;
    end else begin
      state <= next_state;
      if (take_part_write) begin
        hold_addr <= mem_addr;
        hold_data <= mem_wdata;
        hold_mask <= req_mask;
      end
    end
  end

  // read answer, one cycle after acceptance
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h00000000;
      mem_rerr <= 1'b0;
    end else begin
      mem_rvalid <= take_read;
      if (take_read) begin
        mem_rdata <= dec_data;
        mem_rerr <= dec_double;
      end
    end
  end

  // error events come from decoded reads and from merge reads
  assign ev_single = (take_read || (state == ST_MERGE)) && dec_single;
  assign ev_double = (take_read || (state == ST_MERGE)) && dec_double;

  // register write strobes, one per writable offset
  assign clear_wr = reg_wr && reg_hit(reg_addr, `SEEC_REG_CLEAR);
  assign enable_wr = reg_wr && reg_hit(reg_addr, `SEEC_REG_ENABLE);
  assign inject_wr = reg_wr && reg_hit(reg_addr, `SEEC_REG_INJECT);

  // next flag values, a new event beats a same-cycle clear
  always @* begin
    next_single_flag = ev_single ||
      (single_bit_err_flag && !(clear_wr && reg_wdata[`SEEC_BIT_SINGLE]));
    next_multi_flag = ev_double ||
      (multi_bit_err_flag && !(clear_wr && reg_wdata[`SEEC_BIT_MULTI]));
  end

  // sticky flags
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      single_bit_err_flag <= 1'b0;
      multi_bit_err_flag <= 1'b0;
    end else begin
      single_bit_err_flag <= next_single_flag;
      multi_bit_err_flag <= next_multi_flag;
    end
  end

  // flag and enable pairs in register layout
  assign flags = {multi_bit_err_flag, single_bit_err_flag};
  assign enables = {multi_bit_err_nmi_en, single_bit_err_int_en};

  // failing address capture, one register for both kinds
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ecc_error_addr_reg <= `SEEC_RST_ADDR;
    end else if (ev_single || ev_double) begin
      ecc_error_addr_reg <= (state == ST_MERGE) ? hold_addr : mem_addr;
    end
  end

  // flipped bit position capture, kept for diagnosis
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_pos <= `SEEC_RST_POS;
      err_pos_hit <= 1'b0;
    end else if (ev_single || ev_double) begin
      err_pos <= dec_pos;
      err_pos_hit <= dec_pos_hit;
    end
  end

  // interrupt enables, written as a pair
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      single_bit_err_int_en <= RST_EN[`SEEC_BIT_SINGLE];
      multi_bit_err_nmi_en <= RST_EN[`SEEC_BIT_MULTI];
    end else if (enable_wr) begin
      single_bit_err_int_en <= reg_wdata[`SEEC_BIT_SINGLE];
      multi_bit_err_nmi_en <= reg_wdata[`SEEC_BIT_MULTI];
    end
  end

  // test flip mask, xored into data after encoding
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      inject_mask <= `SEEC_RST_INJECT;
    end else if (inject_wr) begin
      inject_mask <= reg_wdata;
    end
  end

  // register read data, valid only in the cycle after the strobe
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SEEC_REG_STATUS: begin
          reg_rdata <= {30'h00000000, flags};
        end
        `SEEC_REG_ENABLE: begin
          reg_rdata <= {30'h00000000, enables};
        end
        `SEEC_REG_ERR_ADDR: begin
          reg_rdata <= {24'h000000, ecc_error_addr_reg};
        end
        `SEEC_REG_ERR_POS: begin
          reg_rdata <= {23'h000000, err_pos_hit, 2'h0, err_pos};
        end
        `SEEC_REG_INJECT: begin
          reg_rdata <= inject_mask;
        end
        default: begin
          reg_rdata <= 32'h00000000; // clear register and holes read zero
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // level interrupts from flag and enable
  assign ecc_irq = single_bit_err_flag && single_bit_err_int_en;
  assign ecc_nmi = multi_bit_err_flag && multi_bit_err_nmi_en;

endmodule // seec_top
`default_nettype wire

// ===== bench/seec_master.sv
/* bus master model for the ecc store's memory port.
   assumes the bench calls access after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module seec_master (
  // clock
  input wire logic core_clk,
  // request out
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_size,
  output logic [7:0] mem_addr,
  output logic [31:0] mem_wdata,
  // answer in
  input wire logic mem_ready
);
  int hung = 0;
  // quiet bus at time zero
  initial begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_size = 2'h0;
    mem_addr = 8'h00;
    mem_wdata = 32'h0;
  end
  // hold the request until taken, bounded wait
  task automatic access(input logic we, input logic [1:0] sz, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    mem_req <= 1'b1;
    mem_we <= we;
    mem_size <= sz;
    mem_addr <= a;
    mem_wdata <= d;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(negedge core_clk);
      ok = mem_ready;
      @(posedge core_clk);
    end
    if (!ok) hung++;
  endtask
  // released lines flip so stale values never pass
  task automatic idle;
    mem_req <= 1'b0;
    mem_addr <= ~mem_addr;
    mem_wdata <= ~mem_wdata;
  endtask
endmodule // seec_master
`default_nettype wire

// ===== bench/seec_top_assertions.sv
/* port assertions of the ecc store.
   assumes one clock, low reset, the defines' offsets. */
`timescale 1ns/10ps
`default_nettype none
`include "seec_defines.vh"
module seec_top_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_size,
  input wire logic [7:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rerr,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // interrupts
  input wire logic ecc_irq,
  input wire logic ecc_nmi
);
  logic [1:0] en;
  wire take = mem_req && mem_ready;
  wire en_w = reg_wr && (reg_addr == `SEEC_REG_ENABLE);
  wire clr_w = reg_wr && (reg_addr == `SEEC_REG_CLEAR);
  wire quiet = mem_ready && !mem_req;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // shadow of the enable register
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      en <= 2'h0;
    else if (en_w)
      en <= reg_wdata[1:0];
  end
  a_read_answer: assert property (take && !mem_we |=> mem_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (mem_rvalid |-> $past(take && !mem_we))
    else $error("answer without read");
  a_merge_stall: assert property (take && mem_we && !mem_size[1] |=> !mem_ready ##1 mem_ready)
    else $error("narrow write merge cycle wrong");
  a_full_no_stall: assert property (take && mem_we && mem_size[1] |=> mem_ready)
    else $error("full write stalled");
  a_nmi_double: assert property (mem_rvalid && mem_rerr && en[1] |-> ecc_nmi)
    else $error("double error without nmi");
  a_irq_gated: assert property (!(ecc_irq && !en[0]) && !(ecc_nmi && !en[1]))
    else $error("interrupt while disabled");
  a_irq_holds: assert property (ecc_irq && !en_w && !(clr_w && reg_wdata[0]) |=> ecc_irq)
    else $error("interrupt dropped");
  a_irq_clear: assert property (clr_w && reg_wdata[0] && quiet |=> !ecc_irq)
    else $error("irq survived clear");
  a_nmi_clear: assert property (clr_w && reg_wdata[1] && quiet |=> !ecc_nmi)
    else $error("nmi survived clear");
  a_rdata_holds: assert property ($changed(mem_rdata) |-> mem_rvalid)
    else $error("read data moved");
  a_set_wins: assert property (take && !mem_we && clr_w && reg_wdata[1] && en[1] |=> !mem_rerr || ecc_nmi)
    else $error("clear beat a new error");
endmodule // seec_top_assertions
bind seec_top seec_top_assertions chk_i (.core_clk(core_clk), .rst_b(rst_b), .mem_req(mem_req),
  .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_rerr(mem_rerr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ecc_irq(ecc_irq), .ecc_nmi(ecc_nmi));
`default_nettype wire

// ===== bench/seec_top_tb.sv
/* self-checking bench of the ecc store, answers matched from queues.
   assumes the master model and the checker file. */
`timescale 1ns/10ps
`default_nettype none
`include "seec_defines.vh"
module seec_top_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  wire mem_req, mem_we, mem_ready, mem_rvalid, mem_rerr, ecc_irq, ecc_nmi;
  wire [1:0] mem_size;
  wire [7:0] mem_addr;
  wire [31:0] mem_wdata, mem_rdata, reg_rdata;
  logic [32:0] mexp[$];
  logic [31:0] rexp[$];
  logic [31:0] img[0:63];
  int failures = 0;
  int n_compared = 0;
  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;
  seec_master m (.core_clk(core_clk), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready));
  seec_top dut (.core_clk(core_clk), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
    .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_rerr(mem_rerr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ecc_irq(ecc_irq), .ecc_nmi(ecc_nmi));
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    failures += m.hung;
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // register strobes, held until idle
  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] e);
    rexp.push_back(e);
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [1:0] sz, input logic [7:0] a, input logic [32:0] e);
    mexp.push_back(e);
    m.access(1'b0, sz, a, $urandom);
  endtask
  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    m.idle();
    @(posedge core_clk);
  endtask
  task automatic lv(input logic ei, input logic en);
    @(negedge core_clk);
    chk("ecc_irq_nmi", {31'h0, ei, en}, {31'h0, ecc_irq, ecc_nmi});
    @(posedge core_clk);
  endtask
  // each answer against the oldest note
  always @(posedge core_clk) begin
    rd_q <= reg_rd;
    if (mem_rvalid === 1'b1)
      chk("mem_rdata", mexp.size() ? mexp.pop_front() : 33'hx, {mem_rerr, mem_rdata});
    if (rd_q)
      chk("reg_rdata", rexp.size() ? {1'b0, rexp.pop_front()} : 33'hx, {1'b0, reg_rdata});
  end
  // run limit
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out();
  end
  initial begin
    logic [31:0] d, inj, msk;
    logic [7:0] a;
    int b;
    void'($urandom(17212));
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values, unmapped offsets read zero
    for (int i = 0; i < 8; i++) rr(8'(i * 4), 32'h0);
    rw(`SEEC_REG_ENABLE, 32'h3);
    rr(`SEEC_REG_ENABLE, 32'h3);
    idle();
    // full word fill, then reads of any size and offset
    for (int i = 0; i < 64; i++) begin
      img[i] = $urandom;
      m.access(1'b1, 2'h2 | 2'($urandom % 2), {6'(i), 2'($urandom)}, img[i]);
    end
    for (int i = 0; i < 64; i++) rd(2'($urandom % 3), {6'(i), 2'($urandom)}, {1'b0, img[i]});
    // narrow writes merge into the stored word
    for (int i = 0; i < 24; i++) begin
      a = 8'($urandom);
      d = $urandom;
      b = $urandom % 2;
      msk = b ? 32'hffff << (16 * a[1]) : 32'hff << (8 * a[1:0]);
      img[a[7:2]] = (img[a[7:2]] & ~msk) | (d & msk);
      m.access(1'b1, 2'(b), a, d);
      rd(2'h2, a, {1'b0, img[a[7:2]]});
    end
    idle();
    // one then two flipped bits: flags, address, position, clear
    for (int k = 0; k < 2; k++) begin
      b = $urandom % 32;
      a = {6'($urandom), 2'h0};
      inj = (32'h1 << b) | (k ? 32'h1 << ((b + 9) % 32) : 32'h0);
      rw(`SEEC_REG_INJECT, inj);
      idle();
      m.access(1'b1, 2'h2, a, img[a[7:2]]);
      idle();
      rw(`SEEC_REG_INJECT, 32'h0);
      // a clear strobe meets the erroring read, the new event must win
      reg_addr <= `SEEC_REG_CLEAR;
      reg_wdata <= 32'h3;
      rd(2'h0, a + 8'(k), {k[0], k ? img[a[7:2]] ^ inj : img[a[7:2]]});
      idle();
      rr(`SEEC_REG_STATUS, k ? 32'h2 : 32'h1);
      rr(`SEEC_REG_ERR_ADDR, {24'h0, a + 8'(k)});
      if (k == 0) rr(`SEEC_REG_ERR_POS, 32'h100 | 32'(b));
      idle();
      lv(k == 0, k == 1);
      rw(`SEEC_REG_ENABLE, 32'h0);
      idle();
      lv(1'b0, 1'b0);
      rw(`SEEC_REG_ENABLE, 32'h3);
      rw(`SEEC_REG_CLEAR, 32'h0);
      idle();
      lv(k == 0, k == 1);
      rw(`SEEC_REG_CLEAR, 32'h3);
      idle();
      lv(1'b0, 1'b0);
    end
    repeat (4) @(posedge core_clk);
    chk("pending", 33'h0, 33'(mexp.size() + rexp.size()));
    close_out();
  end
endmodule // seec_top_tb
`default_nettype wire
